// >>> hdl/pipt_trigger.sv
`timescale 1ns/10ps
module pipt_trigger #(
   parameter int CNT_W = pipt_pkg::PIPT_CNT_W
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // comparator states, high above threshold
   input wire logic input_channel_one,
   input wire logic input_channel_two,
   input wire logic input_channel_three,
   input wire logic input_channel_four,
   input wire logic external_trigger_input,
   // function selection
   input wire pipt_pkg::pipt_fn_t fn_sel,
   input wire logic [2:0] source_sel,
   input wire logic edge_falling,
   input wire logic width_at_or_above,
   input wire logic range_inside,
   input wire pipt_pkg::pipt_iv_t iv_mode,
   input wire logic pattern_exiting,
   // limits in clock cycles
   input wire logic [CNT_W-1:0] limit_low,
   input wire logic [CNT_W-1:0] limit_high,
   // pattern conditions, two bits per input
   input wire logic [2*pipt_pkg::PIPT_NUM_INPUTS-1:0] pattern_cond,
   // hold-off
   input wire pipt_pkg::pipt_ho_t ho_mode,
   input wire logic [CNT_W-1:0] ho_cycles,
   input wire logic [pipt_pkg::PIPT_EVT_W-1:0] ho_events,
   // result
   output logic trigger_out,
   output logic pattern_present
);
   import pipt_pkg::*;

   // elaboration check: timer width must equal the package width
   if (CNT_W != PIPT_CNT_W) begin : g_bad_width
      $error("timer width must match the package width");
   end

   // per-input condition decode, used for every input
   function automatic logic cond_met(input logic [1:0] c, input logic s);
      case (c)
         PIPT_COND_HIGH: cond_met = s;
         PIPT_COND_LOW: cond_met = ~s;
         default: cond_met = 1'b1; // don't care ignored
      endcase
   endfunction

   typedef struct packed {
      logic [CNT_W-1:0] width_tmr; // cycles since opposite edge
      logic [CNT_W-1:0] iv_tmr; // cycles since last like edge
      logic iv_armed; // a first like edge was seen
      logic pat; // registered pattern state
      logic trig; // output pulse
   } pipt_state_t;

   pipt_state_t st; // registered state
   pipt_state_t next_st; // next state

   logic [PIPT_NUM_INPUTS-1:0] in_vec; // all comparator states
   logic [PIPT_NUM_INPUTS-1:0] rise_vec; // rising edges
   logic [PIPT_NUM_INPUTS-1:0] fall_vec; // falling edges
   logic [PIPT_NUM_INPUTS-1:0] met_vec; // condition satisfied
   logic src_rise; // selected source rising
   logic src_fall; // selected source falling
   logic sel_edge; // chosen edge on source
   logic opp_edge; // opposite edge on source
   logic pat_now; // pattern as seen this cycle
   logic [CNT_W-1:0] w_meas; // pulse width measured
   logic [CNT_W-1:0] i_meas; // interval measured
   logic w_le_lo; // width at or below low limit
   logic w_ge_lo; // width at or above low limit
   logic w_ge_hi; // width at or above high limit
   logic w_le_hi; // width at or below high limit
   logic cand; // candidate trigger before hold-off
   logic fire; // qualified trigger

   // comparator states already give high above threshold
   assign in_vec = {external_trigger_input, input_channel_four,
                    input_channel_three, input_channel_two,
                    input_channel_one};

   // one edge detector per input
   for (genvar i = 0; i < PIPT_NUM_INPUTS; i++) begin : g_in
      pipt_edge_det u_edge (
         .clk_sys(clk_sys),
         .rst_n(rst_n),
         .state_in(in_vec[i]),
         .rise(rise_vec[i]),
         .fall(fall_vec[i])
      );
      assign met_vec[i] = cond_met(pattern_cond[2*i +: 2], in_vec[i]);
   end

   // source select; codes above the last input read as no edge
   always_comb begin
      if (source_sel < 3'(PIPT_NUM_INPUTS)) begin
         src_rise = rise_vec[source_sel];
         src_fall = fall_vec[source_sel];
      end else begin
         src_rise = 1'b0;
         src_fall = 1'b0;
      end
   end

   assign sel_edge = edge_falling ? src_fall : src_rise;
   assign opp_edge = edge_falling ? src_rise : src_fall;

   // AND of all conditions; one miss makes it absent
   assign pat_now = &met_vec;

   // count includes the edge cycle itself; a saturated timer stays at
   // full scale so an overlong pulse never wraps round to read narrow
   assign w_meas = (&st.width_tmr) ? st.width_tmr
      : st.width_tmr + CNT_W'(1);
   assign i_meas = (&st.iv_tmr) ? st.iv_tmr
      : st.iv_tmr + CNT_W'(1);

   // width comparisons shared by both width functions
   assign w_le_lo = (w_meas <= limit_low);
   assign w_ge_lo = (w_meas >= limit_low);
   assign w_ge_hi = (w_meas >= limit_high);
   assign w_le_hi = (w_meas <= limit_high);

   // candidate selection by function
   always_comb begin
      cand = 1'b0;
      case (fn_sel)
         PIPT_FN_WIDTH: begin
            // low limit is the single width limit
            if (width_at_or_above) begin
               cand = sel_edge & w_ge_lo;
            end else begin
               cand = sel_edge & w_le_lo;
            end
         end
         PIPT_FN_RANGE: begin
            if (range_inside) begin
               cand = sel_edge & w_ge_lo & w_le_hi;
            end else begin
               cand = sel_edge & (w_le_lo | w_ge_hi);
            end
         end
         PIPT_FN_INTERVAL: begin
            // first edge only arms; second like edge decides
            if (sel_edge && st.iv_armed) begin
               case (iv_mode)
                  PIPT_IV_SHORTER: cand = (i_meas <= limit_high);
                  PIPT_IV_LONGER: cand = (i_meas > limit_low);
                  PIPT_IV_INSIDE: cand = (i_meas >= limit_low) &&
                     (i_meas <= limit_high);
                  PIPT_IV_OUTSIDE: cand = (i_meas < limit_low) ||
                     (i_meas > limit_high);
                  default: cand = 1'b0;
               endcase
            end
         end
         PIPT_FN_PATTERN: begin
            if (pattern_exiting) begin
               cand = st.pat & ~pat_now;
            end else begin
               cand = ~st.pat & pat_now;
            end
         end
         default: cand = 1'b0;
      endcase
   end

   // hold-off qualification
   pipt_holdoff u_holdoff (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ho_mode(ho_mode),
      .ho_cycles(ho_cycles),
      .ho_events(ho_events),
      .cand(cand),
      .fire(fire)
   );

   // next state; timers saturate instead of wrapping, so a very
   // long pulse still reads as long
   always_comb begin
      next_st = st;
      if (st.width_tmr != {CNT_W{1'b1}}) begin
         next_st.width_tmr = w_meas;
      end
      if (st.iv_tmr != {CNT_W{1'b1}}) begin
         next_st.iv_tmr = i_meas;
      end
      if (opp_edge) begin
         next_st.width_tmr = '0;
      end
      if (sel_edge) begin
         next_st.iv_tmr = '0;
         next_st.iv_armed = 1'b1;
      end
      next_st.pat = pat_now;
      next_st.trig = fire;
   end

   // state register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from flip-flops
   assign trigger_out = st.trig;
   assign pattern_present = st.pat;
endmodule // pipt_trigger

// >>> hdl/pipt_pkg.sv
package pipt_pkg;
   // trigger function selection
   typedef enum logic [1:0] {
      PIPT_FN_WIDTH = 2'h0, // single-limit pulse width
      PIPT_FN_RANGE = 2'h1, // pulse width range (in or out)
      PIPT_FN_INTERVAL = 2'h2, // like-edge interval
      PIPT_FN_PATTERN = 2'h3 // five-input pattern
   } pipt_fn_t;

   // interval sub-modes
   typedef enum logic [1:0] {
      PIPT_IV_SHORTER = 2'h0,
      PIPT_IV_LONGER = 2'h1,
      PIPT_IV_INSIDE = 2'h2,
      PIPT_IV_OUTSIDE = 2'h3
   } pipt_iv_t;

   // hold-off kind
   typedef enum logic [1:0] {
      PIPT_HO_NONE = 2'h0,
      PIPT_HO_TIME = 2'h1,
      PIPT_HO_EVENTS = 2'h2
   } pipt_ho_t;

   // per-input pattern condition, two bits each
   localparam logic [1:0] PIPT_COND_DONT_CARE = 2'h0;
   localparam logic [1:0] PIPT_COND_HIGH = 2'h1;
   localparam logic [1:0] PIPT_COND_LOW = 2'h2;
   localparam int PIPT_NUM_INPUTS = 5;

   // timer width: 20 s at 20 MHz is 4e8 cycles, fits 29 bits
   localparam int PIPT_CNT_W = 29;
   localparam int PIPT_EVT_W = 27;
   localparam longint PIPT_CLK_HZ = 20000000;
   localparam longint PIPT_LIMIT_MAX_S = 20;
   localparam longint PIPT_LIMIT_MAX_CYC = PIPT_LIMIT_MAX_S * PIPT_CLK_HZ;
   localparam int PIPT_EVENTS_MAX = 99999999;
   localparam logic [PIPT_CNT_W-1:0] PIPT_CNT_ZERO = '0;
   localparam logic [PIPT_CNT_W-1:0] PIPT_CNT_ONE = 29'h0000001;
   localparam logic [PIPT_EVT_W-1:0] PIPT_EVT_ONE = 27'h0000001;
endpackage

// >>> hdl/pipt_edge_det.sv
`timescale 1ns/10ps
// previous-sample edge detector for one comparator state
module pipt_edge_det (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // comparator state in
   input wire logic state_in,
   // edges out, same cycle as the new sample
   output logic rise,
   output logic fall
);
   import pipt_pkg::*;

   logic prev; // last sampled state

   // keep the previous sample
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prev <= 1'b0;
      end else begin
         prev <= state_in;
      end
   end

   // compare current against previous
   assign rise = state_in & ~prev;
   assign fall = ~state_in & prev;
endmodule // pipt_edge_det

// >>> hdl/pipt_holdoff.sv
`timescale 1ns/10ps
// hold-off gate: passes a candidate only when time or events have passed; with no hold-off it passes every candidate
module pipt_holdoff (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // configuration
   input wire pipt_pkg::pipt_ho_t ho_mode,
   input wire logic [pipt_pkg::PIPT_CNT_W-1:0] ho_cycles,
   input wire logic [pipt_pkg::PIPT_EVT_W-1:0] ho_events,
   // candidate trigger and qualified result
   input wire logic cand,
   output logic fire
);
   import pipt_pkg::*;

   typedef struct packed {
      logic [PIPT_CNT_W-1:0] tmr; // cycles since last trigger
      logic [PIPT_EVT_W-1:0] evt; // events since last trigger
   } pipt_ho_state_t;

   pipt_ho_state_t st; // registered state
   pipt_ho_state_t next_st; // next state
   logic time_ok; // delay elapsed
   logic evt_ok; // enough events skipped

   // timer saturates so a long idle never wraps back into hold-off
   assign time_ok = (st.tmr >= ho_cycles);
   assign evt_ok = (st.evt >= ho_events);

   // gate decision
   always_comb begin
      case (ho_mode)
         PIPT_HO_TIME: fire = cand & time_ok;
         PIPT_HO_EVENTS: fire = cand & evt_ok;
         default: fire = cand;
      endcase
   end

   // counters restart on each trigger
   always_comb begin
      next_st = st;
      if (st.tmr != {PIPT_CNT_W{1'b1}}) begin
         next_st.tmr = st.tmr + PIPT_CNT_ONE;
      end
      if (fire) begin
         next_st.tmr = PIPT_CNT_ONE;
         next_st.evt = '0;
      end else if (cand && !evt_ok) begin
         next_st.evt = st.evt + PIPT_EVT_ONE;
      end
   end

   // state register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{tmr: {PIPT_CNT_W{1'b1}}, evt: {PIPT_EVT_W{1'b1}}};
      end else begin
         st <= next_st;
      end
   end
endmodule // pipt_holdoff

// >>> verification/pipt_trigger_asserts.sv
`timescale 1ns/10ps
// port-level checks for the trigger block
module pipt_trigger_asserts
   import pipt_pkg::*;
#(
   parameter int CNT_W = 29
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // comparator states
   input wire logic input_channel_one,
   input wire logic input_channel_two,
   input wire logic input_channel_three,
   input wire logic input_channel_four,
   input wire logic external_trigger_input,
   // configuration
   input wire pipt_pkg::pipt_fn_t fn_sel,
   input wire logic [2:0] source_sel,
   input wire logic edge_falling,
   input wire logic width_at_or_above,
   input wire logic pattern_exiting,
   input wire logic [CNT_W-1:0] limit_low,
   input wire logic [9:0] pattern_cond,
   input wire pipt_pkg::pipt_ho_t ho_mode,
   input wire logic [CNT_W-1:0] ho_cycles,
   // outputs
   input wire logic trigger_out,
   input wire logic pattern_present
);
   logic [4:0] st; // inputs, channel one at bit 0
   logic src, src_prev; // selected source, now and one sample back
   logic pat; // reference pattern
   logic [CNT_W-1:0] wcnt; // cycles since the opposite edge
   logic [CNT_W-1:0] gap; // cycles since the last trigger
   assign st = {external_trigger_input, input_channel_four,
      input_channel_three, input_channel_two, input_channel_one};
   // an absent source reads low and so never shows an edge
   assign src = (source_sel < 3'h5) ? st[source_sel] : 1'b0;
   // any unmet condition clears the reference pattern
   always_comb begin
      pat = 1'b1;
      for (int i = 0; i < 5; i++) begin
         if ((pattern_cond[2*i+:2] == PIPT_COND_HIGH && !st[i]) ||
            (pattern_cond[2*i+:2] == PIPT_COND_LOW && st[i]))
            pat = 1'b0;
      end
   end
   // gap starts saturated so the first trigger is never held off
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         src_prev <= 1'b0;
         // the block's width timer reads one on the first edge after reset
         wcnt <= CNT_W'(1);
         gap <= '1;
      end else begin
         src_prev <= src;
         wcnt <= (src != src_prev && src == edge_falling) ? CNT_W'(1)
            : wcnt + 1'b1;
         gap <= trigger_out ? CNT_W'(1) : gap + (&gap ? 1'b0 : 1'b1);
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   a_one_cycle: assert property (trigger_out |=> !trigger_out)
      else $error("trigger pulse longer than one cycle");
   a_reset_quiet: assert property ($rose(rst_n) |->
      !trigger_out && !pattern_present) else $error("outputs high at start");
   a_pat_follow: assert property ($past(rst_n) |->
      pattern_present == $past(pat)) else $error("pattern state wrong");
   a_pat_edge: assert property ($past(rst_n) &&
      $past(fn_sel) == PIPT_FN_PATTERN && $past(ho_mode) == PIPT_HO_NONE
      |-> trigger_out == ($past(pattern_exiting) ? $fell(pattern_present)
      : $rose(pattern_present))) else $error("pattern trigger misplaced");
   a_trig_edge: assert property (trigger_out &&
      $past(fn_sel) != PIPT_FN_PATTERN |-> $past(src) != $past(src_prev)
      && $past(src) != $past(edge_falling)) else $error("trigger off edge");
   a_no_source: assert property ($past(source_sel) > 3'h4 &&
      $past(fn_sel) != PIPT_FN_PATTERN |-> !trigger_out)
      else $error("trigger with no source");
   a_width_limit: assert property (trigger_out &&
      $past(fn_sel) == PIPT_FN_WIDTH |-> ($past(width_at_or_above) ?
      $past(wcnt) >= $past(limit_low) : $past(wcnt) <= $past(limit_low)))
      else $error("width trigger outside limit");
   a_hold_time: assert property (trigger_out && ho_mode == PIPT_HO_TIME
      |-> gap + 1 >= ho_cycles) else $error("trigger inside hold-off");
endmodule // pipt_trigger_asserts

// >>> verification/pipt_comp_model.sv
`timescale 1ns/10ps
// five threshold comparators in front of the trigger block
module pipt_comp_model (
   // levels and thresholds, one byte per input, channel one lowest
   input wire logic [39:0] level,
   input wire logic [39:0] thresh,
   // comparator states
   output logic [4:0] state
);
   // a level equal to the threshold reads low; no hysteresis modelled
   always_comb begin
      for (int i = 0; i < 5; i++)
         state[i] = level[8*i+:8] > thresh[8*i+:8];
   end
endmodule // pipt_comp_model

// >>> verification/tb_top.sv
`timescale 1ns/10ps
// scenarios for the trigger block
module tb_top;
   import pipt_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   pipt_fn_t fn_sel = PIPT_FN_WIDTH;
   pipt_iv_t iv_mode = PIPT_IV_SHORTER;
   pipt_ho_t ho_mode = PIPT_HO_NONE;
   logic [2:0] source_sel = 3'h0;
   logic edge_falling = 1'b0, width_at_or_above = 1'b0;
   logic range_inside = 1'b0, pattern_exiting = 1'b0;
   logic [PIPT_CNT_W-1:0] limit_low = '0, limit_high = '0, ho_cycles = '0;
   logic [PIPT_EVT_W-1:0] ho_events = '0;
   logic [9:0] pattern_cond = '0;
   logic [39:0] level = '0, thresh = {5{8'h80}}; // comparator inputs
   logic [4:0] st; // comparator states into the block
   logic trigger_out, pattern_present;
   int n_errors = 0, n_compared = 0, n_trig = 0, t0 = 0;
   pipt_comp_model u_comp (.level, .thresh, .state(st));
   pipt_trigger u_dut (.clk_sys, .rst_n, .input_channel_one(st[0]),
      .input_channel_two(st[1]), .input_channel_three(st[2]),
      .input_channel_four(st[3]), .external_trigger_input(st[4]),
      .fn_sel, .source_sel, .edge_falling, .width_at_or_above,
      .range_inside, .iv_mode, .pattern_exiting, .limit_low, .limit_high,
      .pattern_cond, .ho_mode, .ho_cycles, .ho_events, .trigger_out,
      .pattern_present);
   initial begin
      forever #25 clk_sys = ~clk_sys;
   end
   // pulses are counted mid-cycle, clear of the launching edge
   always @(negedge clk_sys) begin
      if (trigger_out === 1'b1)
         n_trig++;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: saw %0h, expected %0h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // levels from a word of states, channel one at bit 0
   function automatic logic [39:0] wl(input logic [4:0] w);
      for (int i = 0; i < 5; i++)
         wl[8*i+:8] = w[i] ? 8'hA0 : 8'h60;
   endfunction
   // selected source at b, inverted for a falling edge; an absent
   // source moves every input at once
   function automatic logic [39:0] vv(input logic b);
      logic [4:0] w;
      for (int i = 0; i < 5; i++)
         w[i] = (i == source_sel || source_sel > 3'h4) && (b ^ edge_falling);
      return wl(w);
   endfunction
   task automatic lvl(input logic b);
      @(posedge clk_sys);
      level <= vv(b);
   endtask
   // reset under the current configuration, source at rest
   task automatic rst;
      @(posedge clk_sys);
      rst_n <= 1'b0;
      level <= vv(1'b0);
      tick(5);
      rst_n <= 1'b1;
   endtask
   task automatic setw(input pipt_fn_t f, input logic [2:0] s,
      input logic fl, input logic [1:0] m, input int lo, input int hi);
      fn_sel <= f;
      source_sel <= s;
      edge_falling <= fl;
      width_at_or_above <= m[0];
      range_inside <= m[0];
      iv_mode <= pipt_iv_t'(m);
      limit_low <= lo[PIPT_CNT_W-1:0];
      limit_high <= hi[PIPT_CNT_W-1:0];
   endtask
   // one pulse or one like-edge interval of n cycles; a trigger that
   // the reset-time edge may cause is left out of the count
   task automatic meas(input logic ivl, input int n, input int exp);
      rst();
      t0 = n_trig;
      lvl(1'b1);
      if (!ivl) begin
         tick(3);
         t0 = n_trig;
      end
      lvl(1'b0);
      tick(n - (ivl ? 2 : 1));
      lvl(1'b1);
      tick(4);
      chk(n_trig - t0, exp);
   endtask
   task automatic t_width;
      setw(PIPT_FN_WIDTH, 3'h0, 1'b0, 2'h0, 3, 0);
      meas(1'b0, 3, 1);
      meas(1'b0, 4, 0);
      setw(PIPT_FN_WIDTH, 3'h4, 1'b1, 2'h1, 4, 0);
      meas(1'b0, 4, 1);
      meas(1'b0, 3, 0);
      setw(PIPT_FN_WIDTH, 3'h5, 1'b0, 2'h0, 3, 0);
      meas(1'b0, 2, 0);
   endtask
   task automatic t_range;
      setw(PIPT_FN_RANGE, 3'h1, 1'b0, 2'h0, 3, 5);
      meas(1'b0, 3, 1);
      meas(1'b0, 4, 0);
      meas(1'b0, 5, 1);
      setw(PIPT_FN_RANGE, 3'h1, 1'b0, 2'h1, 3, 5);
      meas(1'b0, 4, 1);
      meas(1'b0, 6, 0);
   endtask
   task automatic t_interval;
      setw(PIPT_FN_INTERVAL, 3'h2, 1'b0, 2'h0, 3, 5);
      meas(1'b1, 5, 1);
      meas(1'b1, 6, 0);
      setw(PIPT_FN_INTERVAL, 3'h3, 1'b1, 2'h1, 3, 5);
      meas(1'b1, 4, 1);
      meas(1'b1, 3, 0);
      setw(PIPT_FN_INTERVAL, 3'h2, 1'b0, 2'h2, 3, 5);
      meas(1'b1, 4, 1);
      meas(1'b1, 6, 0);
      setw(PIPT_FN_INTERVAL, 3'h2, 1'b0, 2'h3, 3, 5);
      meas(1'b1, 2, 1);
      meas(1'b1, 6, 1);
      meas(1'b1, 4, 0);
   endtask
   // channel one high, two low, three to five don't care by both codes
   task automatic t_pattern;
      logic [4:0] w [5] = '{5'h01, 5'h11, 5'h03, 5'h00, 5'h0D};
      logic p [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
      for (int e = 0; e < 2; e++) begin
         fn_sel <= PIPT_FN_PATTERN;
         edge_falling <= 1'b0;
         pattern_exiting <= e[0];
         pattern_cond <= 10'h039;
         rst();
         t0 = n_trig;
         for (int k = 0; k < 5; k++) begin
            @(posedge clk_sys);
            level <= wl(w[k]);
            tick(2);
            chk(pattern_present, p[k]);
         end
         tick(2);
         chk(n_trig - t0, 2 - e);
      end
   endtask
   // ten pattern entries, two cycles apart
   task automatic t_holdoff;
      for (int h = 1; h < 3; h++) begin
         ho_mode <= pipt_ho_t'(h);
         pattern_exiting <= 1'b0;
         ho_cycles <= 29'h000000A;
         ho_events <= 27'h0000002;
         rst();
         t0 = n_trig;
         repeat (10) begin
            @(posedge clk_sys);
            level <= wl(5'h01);
            @(posedge clk_sys);
            level <= wl(5'h00);
         end
         tick(3);
         if (h == 1)
            chk(n_trig - t0, 2);
         else
            chk(n_trig - t0, 4);
      end
   endtask
   task automatic finish_test;
      $display("mismatches %0d, comparisons %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      t_width();
      t_range();
      t_interval();
      t_pattern();
      t_holdoff();
      finish_test();
   end
   // the whole run needs well under a thousand cycles
   initial begin
      #(5000 * 50);
      n_errors++;
      finish_test();
   end
endmodule // tb_top
bind pipt_trigger pipt_trigger_asserts #(.CNT_W(CNT_W)) u_chk (
   .clk_sys, .rst_n, .input_channel_one, .input_channel_two,
   .input_channel_three, .input_channel_four, .external_trigger_input,
   .fn_sel, .source_sel, .edge_falling, .width_at_or_above,
   .pattern_exiting, .limit_low, .pattern_cond, .ho_mode, .ho_cycles,
   .trigger_out, .pattern_present);
